// ### include/tpo_pkg.sv
// constants, register map and carrier types of the timing pattern output unit
// assumes a 100 MHz aclk and AXI4-Lite register access with 32-bit data
package tpo_pkg;

  localparam logic [3:0]  TPO_REGION          = 4'h5;
  localparam logic [27:0] TPO_IDX_NEXT_EN_LO  = 28'h05FFFF3;
  localparam logic [27:0] TPO_IDX_PORT_DATA   = 28'h5FFFFC2;
  localparam logic [27:0] TPO_IDX_PIN_FN_HI   = 28'h5FFFFCC;
  localparam logic [27:0] TPO_IDX_PIN_FN_LO   = 28'h5FFFFCE;
  localparam logic [27:0] TPO_IDX_MODE        = 28'h5FFFFF0;
  localparam logic [27:0] TPO_IDX_TRIG_SEL    = 28'h5FFFFF1;
  localparam logic [27:0] TPO_IDX_NEXT_EN_HI  = 28'h5FFFFF2;
  localparam logic [27:0] TPO_IDX_ND_HI_A     = 28'h5FFFFF4;
  localparam logic [27:0] TPO_IDX_ND_LO_A     = 28'h5FFFFF5;
  localparam logic [27:0] TPO_IDX_ND_HI_B     = 28'h5FFFFF6;
  localparam logic [27:0] TPO_IDX_ND_LO_B     = 28'h5FFFFF7;
  localparam logic [27:0] TPO_IDX_QUEUE       = 28'h5FFFFE0;
  localparam logic [27:0] TPO_IDX_CONFIG      = 28'h5FFFFE4;
  localparam logic [27:0] TPO_IDX_STATUS      = 28'h5FFFFE8;

  localparam logic [15:0] TPO_RST_PORT_DATA   = 16'h0000;
  localparam logic [15:0] TPO_RST_PIN_FN      = 16'h0000;
  localparam logic [7:0]  TPO_RST_MODE        = 8'hF0;
  localparam logic [7:0]  TPO_RST_TRIG_SEL    = 8'hFF;
  localparam logic [7:0]  TPO_RST_NEXT_EN     = 8'h00;
  localparam logic [15:0] TPO_RST_NEXT_DATA   = 16'h0000;
  localparam logic [7:0]  TPO_RST_GAP         = 8'h00;

  localparam int          TPO_GROUPS          = 4;
  localparam int          TPO_GROUP_BITS      = 4;
  localparam int          TPO_CFG_QUEUE_EN    = 0;
  localparam int          TPO_CFG_GAP_LSB     = 8;
  localparam logic [1:0]  TPO_PIN_PATTERN     = 2'b11;
  localparam logic [1:0]  TPO_RESP_OKAY       = 2'b00;
  localparam logic [1:0]  TPO_RESP_SLVERR     = 2'b10;

  typedef struct packed {
    logic [7:0] gap;
    logic       queue_en;
  } tpo_cfg_t;

  typedef struct packed {
    logic [27:0] idx;
    logic [31:0] data;
    logic [3:0]  strb;
  } tpo_wreq_t;

endpackage : tpo_pkg

// ### rtl/tpo_fifo.sv
// pattern word queue with a registered read stage
// assumes one clock and a synchronous active-low reset
module tpo_fifo
  import tpo_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("tpo_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic             push;
  logic             load;

  assign in_ready  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign push      = in_valid & in_ready;
  assign load      = (count_reg != '0) & (~out_valid_reg | out_ready);
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      out_valid_reg <= load | (out_valid_reg & ~out_ready);
      if (load) begin
        out_data_reg <= mem_reg[rd_ptr_reg];
      end
    end
  end

endmodule : tpo_fifo

// ### rtl/tpo_unit.sv
// timing pattern output unit with AXI4-Lite registers
// assumes compare_match pulses come from the timer on aclk, pins are resolved outside
//
// Chosen here: the AXI4-Lite interface to the registers.
module tpo_unit
  import tpo_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  compare_match,
  output logic [15:0]      pattern_out,
  output logic [15:0]      pattern_oe,
  output logic             dma_req
);

  initial begin
    if (QUEUE_DEPTH < 2) begin
      $error("tpo_unit: queue depth too small");
    end
  end

  // register index hit, only the region nibble and low nine bits count
  function automatic logic hit(input logic [29:0] idx, input logic [27:0] off);
    hit = (idx[27:24] == TPO_REGION) && (idx[8:0] == off[8:0]);
  endfunction : hit

  // byte lane mask for the low two lanes
  function automatic logic [15:0] lanes(input logic [3:0] strb);
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lanes

  logic             aw_held_reg;
  logic             w_held_reg;
  tpo_wreq_t        wreq_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  logic [15:0]      port_data_reg;
  logic [15:0]      port_data_next;
  logic [15:0]      pin_fn_hi_reg;
  logic [15:0]      pin_fn_lo_reg;
  logic [7:0]       mode_reg;
  logic [7:0]       trig_sel_reg;
  logic [7:0]       next_en_lo_reg;
  logic [7:0]       next_en_hi_reg;
  logic [15:0]      next_data_reg;
  tpo_cfg_t         cfg_reg;
  logic             need_reg;

  logic [3:0]       match_reg;
  logic [3:0]       fire;
  logic [3:0]       pend_reg;
  logic [7:0]       gap_cnt_reg [TPO_GROUPS];
  logic [3:0]       held_reg    [TPO_GROUPS];
  logic             dma_req_reg;

  logic             lo_shared;
  logic             hi_shared;
  logic [15:0]      enables;
  logic             write_ok;
  logic             do_write;
  logic             wr_hit;
  logic             wr_queue;
  logic [15:0]      wmask;
  logic [29:0]      widx;
  logic [29:0]      ridx;
  logic [31:0]      rd_value;
  logic             rd_hit;
  logic             q_in_ready;
  logic             q_out_valid;
  logic [15:0]      q_out_data;
  logic             q_pop;

  assign lo_shared = (trig_sel_reg[1:0] == trig_sel_reg[3:2]);
  assign hi_shared = (trig_sel_reg[5:4] == trig_sel_reg[7:6]);
  assign enables   = {next_en_hi_reg, next_en_lo_reg};
  assign widx      = wreq_reg.idx[27:0] + 30'h0;
  assign wmask     = lanes(wreq_reg.strb);
  assign wr_queue  = hit(widx, TPO_IDX_QUEUE);

  // write channel, address and data taken in either order
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign write_ok      = ~wr_queue | q_in_ready;
  assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg & write_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      wreq_reg    <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg  <= 1'b1;
        wreq_reg.idx <= s_axi_awaddr[29:2];
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg    <= 1'b1;
        wreq_reg.data <= s_axi_wdata;
        wreq_reg.strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (hit(widx, TPO_IDX_PORT_DATA) || hit(widx, TPO_IDX_PIN_FN_HI) || hit(widx, TPO_IDX_PIN_FN_LO) ||
        hit(widx, TPO_IDX_MODE) || hit(widx, TPO_IDX_TRIG_SEL) || hit(widx, TPO_IDX_NEXT_EN_HI) ||
        hit(widx, TPO_IDX_NEXT_EN_LO) || hit(widx, TPO_IDX_ND_HI_A) || hit(widx, TPO_IDX_ND_LO_A) ||
        hit(widx, TPO_IDX_ND_HI_B) || hit(widx, TPO_IDX_ND_LO_B) || wr_queue ||
        hit(widx, TPO_IDX_CONFIG) || hit(widx, TPO_IDX_STATUS)) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= TPO_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? TPO_RESP_OKAY : TPO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_fn_hi_reg  <= TPO_RST_PIN_FN;
      pin_fn_lo_reg  <= TPO_RST_PIN_FN;
      mode_reg       <= TPO_RST_MODE;
      trig_sel_reg   <= TPO_RST_TRIG_SEL;
      next_en_lo_reg <= TPO_RST_NEXT_EN;
      next_en_hi_reg <= TPO_RST_NEXT_EN;
      cfg_reg        <= '{gap: TPO_RST_GAP, queue_en: 1'b0};
    end else if (do_write && wreq_reg.strb[0]) begin
      if (hit(widx, TPO_IDX_PIN_FN_HI)) begin
        pin_fn_hi_reg <= (pin_fn_hi_reg & ~wmask) | (wreq_reg.data[15:0] & wmask);
      end
      if (hit(widx, TPO_IDX_PIN_FN_LO)) begin
        pin_fn_lo_reg <= (pin_fn_lo_reg & ~wmask) | (wreq_reg.data[15:0] & wmask);
      end
      if (hit(widx, TPO_IDX_MODE)) begin
        mode_reg <= wreq_reg.data[7:0];
      end
      if (hit(widx, TPO_IDX_TRIG_SEL)) begin
        trig_sel_reg <= wreq_reg.data[7:0];
      end
      if (hit(widx, TPO_IDX_NEXT_EN_LO)) begin
        next_en_lo_reg <= wreq_reg.data[7:0];
      end
      if (hit(widx, TPO_IDX_NEXT_EN_HI)) begin
        next_en_hi_reg <= wreq_reg.data[7:0];
      end
      if (hit(widx, TPO_IDX_CONFIG)) begin
        cfg_reg.queue_en <= wreq_reg.data[TPO_CFG_QUEUE_EN];
        if (wreq_reg.strb[1]) begin
          cfg_reg.gap <= wreq_reg.data[TPO_CFG_GAP_LSB +: 8];
        end
      end
    end
  end

  // staged next data, from software or from the queue
  assign q_pop = q_out_valid & need_reg & cfg_reg.queue_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_data_reg <= TPO_RST_NEXT_DATA;
    end else if (q_pop) begin
      next_data_reg <= q_out_data;
    end else if (do_write && wreq_reg.strb[0]) begin
      if (hit(widx, TPO_IDX_ND_LO_A)) begin
        next_data_reg[7:4] <= wreq_reg.data[7:4];
        if (lo_shared) begin
          next_data_reg[3:0] <= wreq_reg.data[3:0];
        end
      end
      if (hit(widx, TPO_IDX_ND_LO_B) && !lo_shared) begin
        next_data_reg[3:0] <= wreq_reg.data[3:0];
      end
      if (hit(widx, TPO_IDX_ND_HI_A)) begin
        next_data_reg[15:12] <= wreq_reg.data[7:4];
        if (hi_shared) begin
          next_data_reg[11:8] <= wreq_reg.data[3:0];
        end
      end
      if (hit(widx, TPO_IDX_ND_HI_B) && !hi_shared) begin
        next_data_reg[11:8] <= wreq_reg.data[3:0];
      end
    end
  end

  // a fired trigger consumes the staged word, a pop refills it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      need_reg <= 1'b1;
    end else if (q_pop) begin
      need_reg <= 1'b0;
    end else if (|fire) begin
      need_reg <= 1'b1;
    end
  end

  tpo_fifo #(
    .WIDTH (16),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (aw_held_reg & w_held_reg & ~bvalid_reg & wr_queue & wreq_reg.strb[0]),
    .in_ready  (q_in_ready),
    .in_data   (wreq_reg.data[15:0]),
    .out_valid (q_out_valid),
    .out_ready (q_pop),
    .out_data  (q_out_data)
  );

  // compare matches registered, then mapped to groups by selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_reg <= 4'h0;
    end else begin
      match_reg <= compare_match;
    end
  end

  always_comb begin
    for (int g = 0; g < TPO_GROUPS; g++) begin
      fire[g] = match_reg[trig_sel_reg[2*g +: 2]];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_req_reg <= 1'b0;
    end else begin
      dma_req_reg <= |fire;
    end
  end

  // non-overlap: rising bits wait the gap after the falling ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 4'h0;
      for (int g = 0; g < TPO_GROUPS; g++) begin
        gap_cnt_reg[g] <= 8'h00;
        held_reg[g]    <= 4'h0;
      end
    end else begin
      for (int g = 0; g < TPO_GROUPS; g++) begin
        if (fire[g] && mode_reg[g]) begin
          pend_reg[g]    <= 1'b1;
          gap_cnt_reg[g] <= cfg_reg.gap;
          held_reg[g]    <= next_data_reg[4*g +: 4];
        end else if (pend_reg[g] && gap_cnt_reg[g] == 8'h00) begin
          pend_reg[g] <= 1'b0;
        end else if (pend_reg[g]) begin
          gap_cnt_reg[g] <= gap_cnt_reg[g] - 8'h01;
        end
      end
    end
  end

  always_comb begin
    logic [3:0] m;
    logic [3:0] cur;
    m   = 4'h0;
    cur = 4'h0;
    port_data_next = port_data_reg;
    if (do_write && hit(widx, TPO_IDX_PORT_DATA)) begin
      port_data_next = (port_data_reg & ~(wmask & ~enables)) | (wreq_reg.data[15:0] & wmask & ~enables);
    end
    for (int g = 0; g < TPO_GROUPS; g++) begin
      m   = enables[4*g +: 4];
      cur = port_data_next[4*g +: 4];
      if (fire[g] && !mode_reg[g]) begin
        port_data_next[4*g +: 4] = (cur & ~m) | (next_data_reg[4*g +: 4] & m);
      end else if (fire[g]) begin
        port_data_next[4*g +: 4] = cur & ~(m & ~next_data_reg[4*g +: 4]);
      end else if (pend_reg[g] && gap_cnt_reg[g] == 8'h00) begin
        port_data_next[4*g +: 4] = (cur & ~m) | (held_reg[g] & m);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_data_reg <= TPO_RST_PORT_DATA;
    end else begin
      port_data_reg <= port_data_next;
    end
  end

  // read channel
  assign ridx          = s_axi_araddr[31:2];
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    if (hit(ridx, TPO_IDX_PORT_DATA)) begin
      rd_value[15:0] = port_data_reg;
    end else if (hit(ridx, TPO_IDX_PIN_FN_HI)) begin
      rd_value[15:0] = pin_fn_hi_reg;
    end else if (hit(ridx, TPO_IDX_PIN_FN_LO)) begin
      rd_value[15:0] = pin_fn_lo_reg;
    end else if (hit(ridx, TPO_IDX_MODE)) begin
      rd_value[7:0] = mode_reg;
    end else if (hit(ridx, TPO_IDX_TRIG_SEL)) begin
      rd_value[7:0] = trig_sel_reg;
    end else if (hit(ridx, TPO_IDX_NEXT_EN_HI)) begin
      rd_value[7:0] = next_en_hi_reg;
    end else if (hit(ridx, TPO_IDX_NEXT_EN_LO)) begin
      rd_value[7:0] = next_en_lo_reg;
    end else if (hit(ridx, TPO_IDX_ND_LO_A)) begin
      rd_value[7:0] = lo_shared ? next_data_reg[7:0] : {next_data_reg[7:4], 4'hF};
    end else if (hit(ridx, TPO_IDX_ND_LO_B)) begin
      rd_value[7:0] = lo_shared ? 8'hFF : {4'hF, next_data_reg[3:0]};
    end else if (hit(ridx, TPO_IDX_ND_HI_A)) begin
      rd_value[7:0] = hi_shared ? next_data_reg[15:8] : {next_data_reg[15:12], 4'hF};
    end else if (hit(ridx, TPO_IDX_ND_HI_B)) begin
      rd_value[7:0] = hi_shared ? 8'hFF : {4'hF, next_data_reg[11:8]};
    end else if (hit(ridx, TPO_IDX_CONFIG)) begin
      rd_value[TPO_CFG_QUEUE_EN]      = cfg_reg.queue_en;
      rd_value[TPO_CFG_GAP_LSB +: 8]  = cfg_reg.gap;
    end else if (hit(ridx, TPO_IDX_STATUS)) begin
      rd_value[2:0] = {pend_reg != 4'h0, q_out_valid, ~q_in_ready};
      rd_value[3]   = need_reg;
    end else if (!hit(ridx, TPO_IDX_QUEUE)) begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= TPO_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_hit ? TPO_RESP_OKAY : TPO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // pins drive only where both function bits select pattern output
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pattern_oe[p]     = (pin_fn_lo_reg[2*p +: 2] == TPO_PIN_PATTERN);
      pattern_oe[p + 8] = (pin_fn_hi_reg[2*p +: 2] == TPO_PIN_PATTERN);
    end
  end

  assign pattern_out = port_data_reg;
  assign dma_req     = dma_req_reg;

endmodule : tpo_unit

// ### sim/tpo_load.sv
// load model: pin level seen by the loads on the pattern pins
// assumes undriven pins are pulled low
module tpo_load (
  input  wire logic [15:0] pattern_out,
  input  wire logic [15:0] pattern_oe,
  output logic      [15:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_level = pattern_out & pattern_oe;
endmodule : tpo_load

// ### sim/tpo_unit_sva.sv
// checker for the timing pattern output unit, watching its ports only
// assumes it is bound into tpo_unit from the bench top file
module tpo_unit_sva
  import tpo_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [3:0]  compare_match,
  input wire logic [15:0] pattern_out,
  input wire logic [15:0] pattern_oe,
  input wire logic        dma_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_write_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_lat: assert property (p_write_lat) else $error("write answer late");
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  property p_dma_cause;
    dma_req |-> $past(compare_match, 2) != 4'h0;
  endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("dma request without match");
  property p_dma_pulse;
    dma_req |=> !dma_req;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma request too long");
  property p_pat_cause;
    $changed(pattern_out) |-> $rose(s_axi_bvalid) || $past(compare_match, 2) != 4'h0 ||
                              $past(compare_match, 3) != 4'h0;
  endproperty
  a_pat_cause: assert property (p_pat_cause) else $error("pattern changed without cause");
  property p_oe_cause;
    $changed(pattern_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("enable changed without write");
endmodule : tpo_unit_sva

// ### sim/tpo_unit_tb.sv
// bench for the timing pattern output unit: register, pattern and queue tests
// assumes tpo_pkg, the checker and the load model are compiled first
module tpo_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tpo_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dma_req;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb, compare_match;
  logic [15:0] pattern_out, pattern_oe, pin_level;
  int          err_total, tests_run, cyc, dma_cnt, n;
  logic [15:0] sep[4] = '{16'h3CA7, 16'h3C97, 16'h3397, 16'h2397};

  tpo_unit #(.QUEUE_DEPTH(16)) tpo_unit_i (.*);
  tpo_load tpo_load_i (.pattern_out, .pattern_oe, .pin_level);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [27:0] idx, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= {2'b00, TPO_REGION, idx[23:0], 2'b00};
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [27:0] idx);
    @(posedge aclk);
    s_axi_araddr  <= {2'b00, TPO_REGION, idx[23:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input string nm, input logic [27:0] idx, input logic [31:0] e);
    rd(idx);
    chk(nm, {r, d}, {TPO_RESP_OKAY, e});
  endtask : rc

  task automatic pulse(input int c);
    @(posedge aclk);
    compare_match <= 4'h1 << c;
    @(posedge aclk);
    compare_match <= 4'h0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : pulse

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    dma_cnt <= dma_cnt + int'(dma_req);
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, compare_match} = 100'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc("mode", TPO_IDX_MODE, 32'hF0);
    rc("trig", TPO_IDX_TRIG_SEL, 32'hFF);
    rc("en_lo", TPO_IDX_NEXT_EN_LO, 32'h00);
    rc("en_hi", TPO_IDX_NEXT_EN_HI, 32'h00);
    rc("fn_hi", TPO_IDX_PIN_FN_HI, 32'h0000);
    rc("port", TPO_IDX_PORT_DATA, 32'h0000);
    rc("nd_lo", TPO_IDX_ND_LO_A, 32'h00);
    rc("alias", 28'h5A001F0, 32'hF0);
    rd(28'h5FFFF00);
    chk("unmapped", {r, d}, {TPO_RESP_SLVERR, 32'h0});
    $display("test reset and decode done");
    wr(TPO_IDX_PIN_FN_LO, 32'h000F);
    wr(TPO_IDX_PIN_FN_HI, 32'hC000);
    rc("fn_lo", TPO_IDX_PIN_FN_LO, 32'h000F);
    chk("oe", pattern_oe, 16'h8003);
    wr(TPO_IDX_PORT_DATA, 32'h9235);
    rc("port_wr", TPO_IDX_PORT_DATA, 32'h9235);
    chk("pins", pin_level, 16'h8001);
    wr(TPO_IDX_NEXT_EN_LO, 32'hFF);
    wr(TPO_IDX_NEXT_EN_HI, 32'h0F);
    wr(TPO_IDX_PORT_DATA, 32'h0000);
    rc("port_ro", TPO_IDX_PORT_DATA, 32'h0235);
    wr(TPO_IDX_NEXT_EN_HI, 32'hFF);
    $display("test pins and port done");
    wr(TPO_IDX_ND_LO_A, 32'hA5);
    wr(TPO_IDX_ND_HI_A, 32'h3C);
    rc("nd_unused", TPO_IDX_ND_LO_B, 32'hFF);
    pulse(2);
    chk("other_ch", pattern_out, 16'h0235);
    pulse(3);
    chk("shared", pattern_out, 16'h3CA5);
    chk("dma", dma_cnt, 1);
    wr(TPO_IDX_NEXT_EN_LO, 32'h0F);
    wr(TPO_IDX_NEXT_EN_HI, 32'h00);
    wr(TPO_IDX_ND_LO_A, 32'h5A);
    wr(TPO_IDX_ND_HI_A, 32'hC3);
    pulse(3);
    chk("partial", pattern_out, 16'h3CAA);
    wr(TPO_IDX_NEXT_EN_LO, 32'hFF);
    wr(TPO_IDX_NEXT_EN_HI, 32'hFF);
    $display("test shared trigger done");
    wr(TPO_IDX_TRIG_SEL, 32'hE4);
    wr(TPO_IDX_ND_LO_A, 32'h96);
    wr(TPO_IDX_ND_LO_B, 32'h87);
    wr(TPO_IDX_ND_HI_A, 32'h21);
    wr(TPO_IDX_ND_HI_B, 32'h43);
    rc("nd_g1", TPO_IDX_ND_LO_A, 32'h9F);
    rc("nd_g0", TPO_IDX_ND_LO_B, 32'hF7);
    rc("nd_g3", TPO_IDX_ND_HI_A, 32'h2F);
    rc("nd_g2", TPO_IDX_ND_HI_B, 32'hF3);
    for (int c = 0; c < 4; c++) begin
      pulse(c);
      chk("separate", pattern_out, sep[c]);
    end
    $display("test separate triggers done");
    wr(TPO_IDX_MODE, 32'hF1);
    wr(TPO_IDX_ND_LO_B, 32'hF8);
    @(posedge aclk);
    compare_match <= 4'h1;
    @(posedge aclk);
    compare_match <= 4'h0;
    @(posedge aclk);
    @(negedge aclk);
    chk("gap_clear", pattern_out, 16'h2390);
    @(negedge aclk);
    chk("gap_set", pattern_out, 16'h2398);
    $display("test non-overlap done");
    wr(TPO_IDX_TRIG_SEL, 32'hFF);
    wr(TPO_IDX_CONFIG, 32'h1);
    rd(TPO_IDX_STATUS);
    while (!d[0] && n < 20) begin
      wr(TPO_IDX_QUEUE, 32'h0100 + 32'(n));
      n++;
      rd(TPO_IDX_STATUS);
    end
    chk("fill", 34'(n >= 16 && n <= 18), 34'h1);
    for (int i = 0; i < n; i++) begin
      pulse(3);
      chk("drain", pattern_out, 16'h0100 + 16'(i));
    end
    rd(TPO_IDX_STATUS);
    chk("empty", d[1:0], 2'h0);
    $display("test queue done");
    tally_and_finish();
  end
endmodule : tpo_unit_tb

bind tpo_unit tpo_unit_sva tpo_unit_sva_i (.*);
